/* dv/test_timer_match_and_count_regs.sv */
// Self-checking bench for the timer match and count register block
module test_timer_match_and_count_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import tmc_pkg::*;

  typedef struct packed {
    logic        w;
    logic [7:0]  idx;
    logic [31:0] d;
    logic [1:0]  r;
  } tmc_row_t;

  logic        aclk, aresetn, slow_clk_pin, irq;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          failures, n_checks;
  logic [31:0] c1, c2;
  logic [1:0]  rr;

  // Rows: write data or expected read data, with the expected response
  tmc_row_t rows [8] = '{
    '{1'h1, IDX_MATCH, 32'h0000_00a5, RESP_OKAY},
    '{1'h0, IDX_MATCH, 32'h0000_00a5, RESP_OKAY},
    '{1'h1, IDX_COUNT, 32'h0000_005a, RESP_OKAY},
    '{1'h0, IDX_COUNT, 32'h0000_005a, RESP_OKAY},
    '{1'h1, IDX_MATCH, 32'h0000_01ff, RESP_OKAY},
    '{1'h0, IDX_MATCH, 32'h0000_00ff, RESP_OKAY},
    '{1'h0, 8'h07,     32'h0000_0000, RESP_SLVERR},
    '{1'h1, 8'h07,     32'h0000_0000, RESP_SLVERR}
  };

  tmc_timer u_tmc_timer (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .slow_clk_pin  (slow_clk_pin),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awprot  (3'h0),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (4'hf),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arprot  (3'h0),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .irq           (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Outputs are registered, so values seen at the edge are the pre-edge ones
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= {2'b00, idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= {2'b00, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1 && s_axi_rvalid !== 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(idx, d, r);
    chk(d, exp);
    chk(r, er);
  endtask

  task automatic wait_irq(input logic lvl, input int lim);
    int k;
    k = 0;
    while (irq !== lvl && k < lim) begin
      @(posedge aclk);
      k++;
    end
    chk(irq, lvl);
  endtask

  // Slow pin only toggles inside a burst and rests low between them
  task automatic slow_edges(input int n);
    repeat (n) begin
      slow_clk_pin <= 1'b1;
      repeat (6) @(posedge aclk);
      slow_clk_pin <= 1'b0;
      repeat (6) @(posedge aclk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    give_verdict();
  end

  initial begin
    aresetn <= 1'b0;
    slow_clk_pin <= 1'b0;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    s_axi_awaddr <= 12'h000;
    s_axi_araddr <= 12'h000;
    s_axi_wdata <= 32'h0000_0000;
    failures = 0;
    n_checks = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(IDX_MATCH, 32'h0000_0000, RESP_OKAY);
    rd_chk(IDX_COUNT, 32'h0000_0000, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      if (rows[i].w) wr(rows[i].idx, rows[i].d, rows[i].r);
      else rd_chk(rows[i].idx, rows[i].d, rows[i].r);
    end
    $display("register table rows done");
    // Slow source selected: writes dropped, count read masked
    wr(IDX_CTRL, 32'h0000_0008, RESP_OKAY);
    wr(IDX_MATCH, 32'h0000_0011, RESP_OKAY);
    wr(IDX_COUNT, 32'h0000_0022, RESP_OKAY);
    rd_chk(IDX_COUNT, 32'h0000_0000, RESP_OKAY);
    wr(IDX_CTRL, 32'h0000_0028, RESP_OKAY);
    rd_chk(IDX_COUNT, 32'h0000_005a, RESP_OKAY);
    wr(IDX_CTRL, 32'h0000_0000, RESP_OKAY);
    rd_chk(IDX_MATCH, 32'h0000_00ff, RESP_OKAY);
    rd_chk(IDX_COUNT, 32'h0000_005a, RESP_OKAY);
    $display("write lockout done");
    // System clock counting to match, flag, mask and clear
    wr(IDX_IRQ_ENABLE, 32'h0000_0001, RESP_OKAY);
    wr(IDX_MATCH, 32'h0000_0003, RESP_OKAY);
    wr(IDX_COUNT, 32'h0000_0000, RESP_OKAY);
    wr(IDX_CTRL, 32'h0000_0010, RESP_OKAY);
    wait_irq(1'b1, 20);
    wr(IDX_CTRL, 32'h0000_0040, RESP_OKAY);
    rd_chk(IDX_CTRL, 32'h0000_0040, RESP_OKAY);
    rd_chk(IDX_IRQ_STATUS, 32'h0000_0001, RESP_OKAY);
    rd(IDX_COUNT, c1, rr);
    repeat (10) @(posedge aclk);
    rd(IDX_COUNT, c2, rr);
    chk(c2, c1);
    chk(32'(c1 <= 32'h0000_0003), 32'h0000_0001);
    wr(IDX_IRQ_ENABLE, 32'h0000_0000, RESP_OKAY);
    chk(irq, 1'b0);
    wr(IDX_IRQ_ENABLE, 32'h0000_0001, RESP_OKAY);
    chk(irq, 1'b1);
    wr(IDX_IRQ_CLEAR, 32'h0000_0001, RESP_OKAY);
    wait_irq(1'b0, 4);
    rd_chk(IDX_IRQ_STATUS, 32'h0000_0000, RESP_OKAY);
    $display("system clock count done");
    // Slowest prescale: the first tick needs 2048 source ticks, so the count stays put
    wr(IDX_COUNT, 32'h0000_0000, RESP_OKAY);
    wr(IDX_CTRL, 32'h0000_0017, RESP_OKAY);
    repeat (20) @(posedge aclk);
    rd_chk(IDX_COUNT, 32'h0000_0000, RESP_OKAY);
    wr(IDX_CTRL, 32'h0000_0000, RESP_OKAY);
    $display("prescale check done");
    // Slow source: no count without pin edges, match after three ticks
    wr(IDX_MATCH, 32'h0000_0002, RESP_OKAY);
    wr(IDX_COUNT, 32'h0000_0000, RESP_OKAY);
    wr(IDX_CTRL, 32'h0000_0008, RESP_OKAY);
    wr(IDX_CTRL, 32'h0000_0018, RESP_OKAY);
    repeat (40) @(posedge aclk);
    chk(irq, 1'b0);
    slow_edges(4);
    wait_irq(1'b1, 10);
    wr(IDX_CTRL, 32'h0000_0048, RESP_OKAY);
    wr(IDX_IRQ_CLEAR, 32'h0000_0001, RESP_OKAY);
    wr(IDX_CTRL, 32'h0000_0000, RESP_OKAY);
    $display("slow clock count done");
    // Reset in mid-run clears everything again
    wr(IDX_MATCH, 32'h0000_003c, RESP_OKAY);
    wr(IDX_CTRL, 32'h0000_0010, RESP_OKAY);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(irq, 1'b0);
    rd_chk(IDX_MATCH, 32'h0000_0000, RESP_OKAY);
    rd_chk(IDX_COUNT, 32'h0000_0000, RESP_OKAY);
    rd_chk(IDX_CTRL, 32'h0000_0000, RESP_OKAY);
    $display("mid-run reset done");
    give_verdict();
  end
endmodule

/* verilog/tmc_pkg.sv */
// Package: register map, field layout and timing constants of the timer block
package tmc_pkg;
  // Documented register indices; byte address is four times the index
  localparam logic [7:0]  IDX_MATCH      = 8'h05;
  localparam logic [7:0]  IDX_COUNT      = 8'h06;
  // Own control registers, index form as well
  localparam logic [7:0]  IDX_CTRL       = 8'h10;
  localparam logic [7:0]  IDX_IRQ_STATUS = 8'h11;
  localparam logic [7:0]  IDX_IRQ_ENABLE = 8'h12;
  localparam logic [7:0]  IDX_IRQ_CLEAR  = 8'h13;
  localparam int          ADDR_W         = 12;
  // Control register field positions
  localparam int          CTRL_PSC_LSB   = 0;
  localparam int          CTRL_PSC_MSB   = 2;
  localparam int          CTRL_CLKSEL    = 3;
  localparam int          CTRL_RUN       = 4;
  localparam int          CTRL_VALID     = 5;
  localparam int          CTRL_FLAG      = 6;
  // Reset values
  localparam logic [7:0]  MATCH_RST      = 8'h00;
  localparam logic [7:0]  COUNT_RST      = 8'h00;
  localparam logic [2:0]  PSC_RST        = 3'h0;
  // Slow reference clock and system clock
  localparam int          SLOW_CLK_HZ    = 32768;
  localparam int          SYS_CLK_HZ     = 40000000;
  // Slow clock edges resolve in the system domain after this many cycles
  localparam int          SYNC_STAGES    = 2;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_WRESP = 2'b01,
    BUS_RDATA = 2'b10
  } tmc_bus_state_t;
endpackage

/* verilog/tmc_prescaler.sv */
// Prescaler: divides the selected tick source by 1, 4, 16, 64, 256, 512, 1024 or 2048
module tmc_prescaler
  import tmc_pkg::*;
#(
  parameter int DIV_W = 11
) (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Tick source and selection
  input  wire logic       src_tick,
  input  wire logic       run,
  input  wire logic [2:0] psc_sel,
  // Divided tick
  output logic            tick_out
);
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] limit;

  always_comb begin
    case (psc_sel)
      3'h0:    limit = DIV_W'(0);
      3'h1:    limit = DIV_W'(3);
      3'h2:    limit = DIV_W'(15);
      3'h3:    limit = DIV_W'(63);
      3'h4:    limit = DIV_W'(255);
      3'h5:    limit = DIV_W'(511);
      3'h6:    limit = DIV_W'(1023);
      default: limit = DIV_W'(2047);
    endcase
  end

  // Divider is held in reset while stopped so restart phase is known
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      div_q    <= '0;
      tick_out <= 1'b0;
    end else if (src_tick) begin
      if (div_q >= limit) begin
        div_q    <= '0;
        tick_out <= 1'b1;
      end else begin
        div_q    <= div_q + DIV_W'(1);
        tick_out <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0;
    end
  end
endmodule

/* verilog/tmc_timer.sv */
// Timer top: match and count registers, control, interrupt, AXI4-Lite slave
//
// The AXI4-Lite slave port was decided locally.
module tmc_timer
  import tmc_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Slow reference clock pin, asynchronous
  input  wire logic        slow_clk_pin,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Interrupt
  output logic             irq
);

  function automatic logic [7:0] reg_index(input logic [11:0] addr);
    return addr[9:2];
  endfunction

  function automatic logic addr_known(input logic [11:0] addr);
    logic [7:0] i;
    i = reg_index(addr);
    return (addr[1:0] == 2'b00) && (addr[11:10] == 2'b00) &&
           (i == IDX_MATCH || i == IDX_COUNT || i == IDX_CTRL ||
            i == IDX_IRQ_STATUS || i == IDX_IRQ_ENABLE || i == IDX_IRQ_CLEAR);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  tmc_bus_state_t bus_q;
  logic           aw_got_q;
  logic           w_got_q;
  logic [11:0]    awaddr_q;
  logic [31:0]    wdata_q;
  logic [3:0]     wstrb_q;
  logic [7:0]     match_q;
  logic [7:0]     count_q;
  logic [2:0]     psc_q;
  logic           clksel_q;
  logic           run_q;
  logic           valid_q;
  logic           flag_q;
  logic           flag_en_q;
  logic [2:0]     slow_sync_q;
  logic           slow_tick;
  logic           src_tick;
  logic           tick;
  logic           wr_fire;
  logic           wr_lane0;
  logic [7:0]     wr_idx;
  logic           match_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Slow clock is sampled as a pin; stages two and three feed the edge detector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slow_sync_q <= 3'b000;
    end else begin
      slow_sync_q <= {slow_sync_q[1:0], slow_clk_pin};
    end
  end
  // Third stage only remembers the previous settled level for edge detection
  assign slow_tick = slow_sync_q[1] & ~slow_sync_q[2];
  assign src_tick  = clksel_q ? slow_tick : 1'b1;

  tmc_prescaler #(
    .DIV_W (11)
  ) u_psc (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .src_tick (src_tick),
    .run      (run_q),
    .psc_sel  (psc_q),
    .tick_out (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; one write and one read in turn, a write whose address or data is already taken goes first
  assign wr_fire  = (bus_q == BUS_IDLE) && aw_got_q && w_got_q;
  assign wr_lane0 = wstrb_q[0];
  assign wr_idx   = reg_index(awaddr_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_q         <= BUS_IDLE;
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      case (bus_q)
        BUS_IDLE: begin
          if (s_axi_awvalid && !aw_got_q && !s_axi_awready) begin
            s_axi_awready <= 1'b1;
            aw_got_q      <= 1'b1;
            awaddr_q      <= s_axi_awaddr;
          end
          if (s_axi_wvalid && !w_got_q && !s_axi_wready) begin
            s_axi_wready <= 1'b1;
            w_got_q      <= 1'b1;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
          end
          if (wr_fire) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= addr_known(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            bus_q        <= BUS_WRESP;
          end else if (s_axi_arvalid && !aw_got_q && !w_got_q) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            case (reg_index(s_axi_araddr))
              IDX_MATCH: s_axi_rdata <= {24'h00_0000, match_q};
              // Slow clock count is unstable until software marks it valid
              IDX_COUNT: s_axi_rdata <= (clksel_q && !valid_q) ? 32'h0000_0000 :
                                        {24'h00_0000, count_q};
              IDX_CTRL: s_axi_rdata <= {25'h000_0000, flag_q, valid_q, run_q,
                                        clksel_q, psc_q};
              IDX_IRQ_STATUS: s_axi_rdata <= {31'h0000_0000, flag_q};
              IDX_IRQ_ENABLE: s_axi_rdata <= {31'h0000_0000, flag_en_q};
              default: s_axi_rdata <= 32'h0000_0000;
            endcase
            if (!addr_known(s_axi_araddr)) begin
              s_axi_rdata <= 32'h0000_0000;
            end
            bus_q <= BUS_RDATA;
          end
        end
        BUS_WRESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            bus_q        <= BUS_IDLE;
          end
        end
        BUS_RDATA: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            bus_q        <= BUS_IDLE;
          end
        end
        default: bus_q <= BUS_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register; select and prescaler only change while stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psc_q     <= PSC_RST;
      clksel_q  <= 1'b0;
      run_q     <= 1'b0;
      valid_q   <= 1'b0;
      flag_en_q <= 1'b0;
    end else if (wr_fire && wr_lane0) begin
      if (wr_idx == IDX_CTRL) begin
        run_q   <= wdata_q[CTRL_RUN];
        valid_q <= wdata_q[CTRL_VALID];
        if (!run_q) begin
          psc_q    <= wdata_q[CTRL_PSC_MSB:CTRL_PSC_LSB];
          clksel_q <= wdata_q[CTRL_CLKSEL];
        end
      end
      if (wr_idx == IDX_IRQ_ENABLE) begin
        flag_en_q <= wdata_q[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Match value register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_q <= MATCH_RST;
    end else if (wr_fire && wr_lane0 && wr_idx == IDX_MATCH && !clksel_q) begin
      match_q <= wdata_q[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter; software load wins over a tick in the same cycle
  assign match_hit = (count_q == match_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= COUNT_RST;
    end else if (wr_fire && wr_lane0 && wr_idx == IDX_COUNT && !clksel_q) begin
      count_q <= wdata_q[7:0];
    end else if (run_q && tick) begin
      count_q <= match_hit ? 8'h00 : count_q + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flag; a set in the clear cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (run_q && tick && match_hit) begin
      flag_q <= 1'b1;
    end else if (wr_fire && wr_lane0 && wr_idx == IDX_IRQ_CLEAR && wdata_q[0]) begin
      flag_q <= 1'b0;
    end else if (wr_fire && wr_lane0 && wr_idx == IDX_CTRL && !wdata_q[CTRL_FLAG]) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      // Set cycle is folded in so the line rises with the flag, not a cycle later
      irq <= (flag_q | (run_q & tick & match_hit)) & flag_en_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_match_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    clksel_q |=> $stable(match_q))
    else $error("match value changed while slow clock selected");
  // A tick may still move the count under the slow source, so only writes are screened
  a_count_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    (clksel_q && wr_fire && wr_idx == IDX_COUNT && !(run_q && tick)) |=> $stable(count_q))
    else $error("count write taken while slow clock selected");
  a_count_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    (!run_q && !(wr_fire && wr_idx == IDX_COUNT)) |=> $stable(count_q))
    else $error("count moved while stopped");
  a_wrap_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (run_q && tick && match_hit && !wr_fire) |=> (count_q == 8'h00) && flag_q)
    else $error("count did not wrap on match");
  a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    (flag_q && !wr_fire) |=> flag_q)
    else $error("flag dropped without software clear");
  a_step_one: assert property (@(posedge aclk) disable iff (!aresetn)
    (run_q && tick && !match_hit && !wr_fire) |=> count_q == $past(count_q) + 8'h01)
    else $error("count did not step by one");
  a_reset_clear: assert property (@(posedge aclk)
    !aresetn |=> (match_q == 8'h00) && (count_q == 8'h00))
    else $error("registers not cleared by reset");
  a_count_load: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_fire && wr_lane0 && wr_idx == IDX_COUNT && !clksel_q)
      |=> count_q == $past(wdata_q[7:0]))
    else $error("count write not loaded");
  a_read_hidden: assert property (@(posedge aclk) disable iff (!aresetn)
    (bus_q == BUS_IDLE && !wr_fire && s_axi_arvalid && !aw_got_q && !w_got_q &&
     addr_known(s_axi_araddr) && reg_index(s_axi_araddr) == IDX_COUNT &&
     clksel_q && !valid_q)
      |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
    else $error("invalid slow count not masked");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    (flag_q && flag_en_q) |=> irq)
    else $error("enabled flag did not raise interrupt");
  // A ready held over two cycles would take one address twice
  a_awready_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held for more than one cycle");
endmodule
